// ---- hdl/iopm_regs.svh ----
// register offsets, field masks and reset values of the pin function multiplexer
`ifndef IOPM_REGS_SVH
`define IOPM_REGS_SVH

// printed register indices; byte address is four times the index
`define IOPM_IDX_SEL_P0 16'h52A0
`define IOPM_IDX_SEL_P1 16'h52A1
`define IOPM_IDX_SEL_P2 16'h52A2
`define IOPM_IDX_SEL_P3 16'h52A3

// byte addresses on the bus
`define IOPM_ADDR_SEL_P0 20'h14A80
`define IOPM_ADDR_SEL_P1 20'h14A84
`define IOPM_ADDR_SEL_P2 20'h14A88
`define IOPM_ADDR_SEL_P3 20'h14A8C
`define IOPM_ADDR_GPIO_DIR 20'h14A90
`define IOPM_ADDR_GPIO_OUT 20'h14A94
`define IOPM_ADDR_GPIO_IN 20'h14A98
`define IOPM_ADDR_IRQ_STATUS 20'h14A9C
`define IOPM_ADDR_IRQ_MASK 20'h14AA0

// implemented select bits per register
`define IOPM_MASK_SEL_P0 8'h30
`define IOPM_MASK_SEL_P1 8'hB8
`define IOPM_MASK_SEL_P2 8'hFF
`define IOPM_MASK_SEL_P3 8'h0F

// per-pin layout over all 28 pins, port zero in the low byte
`define IOPM_PIN_HAS_SEL 28'hFFFB830
`define IOPM_PIN_INV_SEL 28'hE000000
`define IOPM_PIN_SHARED_IN 28'h00040C0

// reset values
`define IOPM_RST_SEL 8'h00
`define IOPM_RST_PINS 28'h0000000
`define IOPM_RST_IRQ 16'h0000

`endif

// ---- hdl/iopm_pkg.sv ----
// types shared by the pin function multiplexer files
package iopm_pkg;

	localparam int unsigned IOPM_PINS = 28;

	// pad drive bundle, one bit per pin
	typedef struct packed {
		logic [IOPM_PINS-1:0] out;
		logic [IOPM_PINS-1:0] oe_n;
	} iopm_pad_t;

	// peripheral side of the pins
	typedef struct packed {
		logic [IOPM_PINS-1:0] out;
		logic [IOPM_PINS-1:0] drive;
	} iopm_periph_t;

endpackage

// ---- hdl/iopm_pin_cell.sv ----
// one pin of the multiplexer: routes a pad to gpio or to its peripheral
`timescale 1ns/1ps
module iopm_pin_cell #(
	parameter bit HAS_SEL = 1'b0,
	parameter bit INV_SEL = 1'b0,
	parameter bit SHARED_IN = 1'b0
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// control
	input wire logic sel_bit,
	input wire logic gpio_dir,
	input wire logic gpio_out,
	// peripheral side
	input wire logic periph_out,
	input wire logic periph_drive,
	output logic periph_in,
	// pad side
	input wire logic pad_in,
	output logic pad_out,
	output logic pad_oe_n,
	output logic gpio_in
);

	logic sel_act;
	logic feed_periph;

	// inverted pins are peripheral-owned while the bit is zero
	assign sel_act = HAS_SEL && (sel_bit ^ INV_SEL);
	// shared inputs see the pad whenever gpio leaves it an input
	assign feed_periph = sel_act || (SHARED_IN && !gpio_dir);

	// pad drive, peripheral owns direction when selected
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pad_out <= 1'b0;
			pad_oe_n <= 1'b1;
		end else if (sel_act) begin
			pad_out <= periph_out;
			pad_oe_n <= !periph_drive;
		end else begin
			pad_out <= gpio_out;
			pad_oe_n <= !gpio_dir;
		end
	end

	// input capture; gpio always sees the pad
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			gpio_in <= 1'b0;
			periph_in <= 1'b0;
		end else begin
			gpio_in <= pad_in;
			periph_in <= feed_periph ? pad_in : 1'b0;
		end
	end

	periph_dir_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		sel_act |=> pad_oe_n == !$past(periph_drive))
		else $error("peripheral did not own pin direction");
	gpio_dir_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!sel_act |=> (pad_oe_n == !$past(gpio_dir)) && (pad_out == $past(gpio_out)))
		else $error("gpio drive not applied to pad");
	shared_in_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(SHARED_IN && !gpio_dir) |=> periph_in == $past(pad_in) && gpio_in == $past(pad_in))
		else $error("shared timer input not fed");

endmodule

// ---- hdl/iopm_pin_mux.sv ----
// pin function multiplexer for 28 pins with apb register access
//
// Functional notes
// - 28 pins in ports of 8,8,8,4; software sets the direction of each pin left to gpio.
// - each shared pin has a select bit; pins without one stay gpio.
// - reset clears every select bit so pins take first function.
// - port zero bits 4,5 route pins to remote control in/out.
// - port one bits 3,4,5,7 route clock out, i2c data, clock, spi select.
// - port two bits 0..7 route spi, uart and timer signals.
// - port three bit 0 clock out; bits 1..3 inverted debug pins.
// - port zero pins 6,7 and port one pin 6 feed timer clocks as inputs.
// - port zero and one pins raise input interrupts; others never.
// - low four port zero pins also serve as key-entry reset inputs.
// - a selected peripheral controls pin direction, ignoring gpio direction.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "iopm_regs.svh"
module iopm_pin_mux #(
	parameter int unsigned ADDR_W = 20
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// pads
	input wire logic [27:0] pad_in,
	output iopm_pkg::iopm_pad_t pads,
	// peripherals
	input wire iopm_pkg::iopm_periph_t periph,
	output logic [27:0] periph_in,
	output logic [3:0] key_reset_in,
	// interrupt
	output logic irq
);

	logic [7:0] sel_p0_reg;
	logic [7:0] sel_p1_reg;
	logic [7:0] sel_p2_reg;
	logic [7:0] sel_p3_reg;
	logic [27:0] gpio_dir_reg;
	logic [27:0] gpio_out_reg;
	logic [15:0] irq_status_reg;
	logic [15:0] irq_status_next;
	logic [15:0] irq_mask_reg;
	logic [15:0] gpio_prev_reg;
	logic [15:0] pin_event;
	logic [27:0] sel_all;
	logic [27:0] gpio_in_w;
	logic [27:0] pad_out_w;
	logic [27:0] pad_oe_n_w;
	logic [31:0] wmask;
	logic [31:0] rdata_next;
	logic addr_hit;
	logic setup_ph;
	logic wr_done;
	logic in_valid_reg;
	logic evt_armed_reg;

	// per-pin layout as indexable constants, one bit handed to each cell
	localparam logic [27:0] PIN_HAS_SEL = `IOPM_PIN_HAS_SEL;
	localparam logic [27:0] PIN_INV_SEL = `IOPM_PIN_INV_SEL;
	localparam logic [27:0] PIN_SHARED_IN = `IOPM_PIN_SHARED_IN;

	// apb phases; a write lands only at the completing access edge
	assign setup_ph = psel && !penable;
	assign wr_done = psel && penable && pready && pwrite && addr_hit;
	assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

	// read decode, narrow registers zero-extended
	always_comb begin
		addr_hit = 1'b1;
		rdata_next = 32'h00000000;
		case (paddr)
			`IOPM_ADDR_SEL_P0: rdata_next = {24'h000000, sel_p0_reg};
			`IOPM_ADDR_SEL_P1: rdata_next = {24'h000000, sel_p1_reg};
			`IOPM_ADDR_SEL_P2: rdata_next = {24'h000000, sel_p2_reg};
			`IOPM_ADDR_SEL_P3: rdata_next = {24'h000000, sel_p3_reg};
			`IOPM_ADDR_GPIO_DIR: rdata_next = {4'h0, gpio_dir_reg};
			`IOPM_ADDR_GPIO_OUT: rdata_next = {4'h0, gpio_out_reg};
			`IOPM_ADDR_GPIO_IN: rdata_next = {4'h0, gpio_in_w};
			`IOPM_ADDR_IRQ_STATUS: rdata_next = {16'h0000, irq_status_reg};
			`IOPM_ADDR_IRQ_MASK: rdata_next = {16'h0000, irq_mask_reg};
			default: addr_hit = 1'b0;
		endcase
	end

	// one wait-free access phase: ready rises on the first access cycle
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= setup_ph;
			pslverr <= setup_ph && !addr_hit;
			if (setup_ph) begin
				prdata <= pwrite ? 32'h00000000 : rdata_next;
			end
		end
	end

	// select registers; masks keep unimplemented bits at zero
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			sel_p0_reg <= `IOPM_RST_SEL;
			sel_p1_reg <= `IOPM_RST_SEL;
			sel_p2_reg <= `IOPM_RST_SEL;
			sel_p3_reg <= `IOPM_RST_SEL;
		end else if (wr_done && pstrb[0]) begin
			case (paddr)
				`IOPM_ADDR_SEL_P0: sel_p0_reg <= pwdata[7:0] & `IOPM_MASK_SEL_P0;
				`IOPM_ADDR_SEL_P1: sel_p1_reg <= pwdata[7:0] & `IOPM_MASK_SEL_P1;
				`IOPM_ADDR_SEL_P2: sel_p2_reg <= pwdata[7:0] & `IOPM_MASK_SEL_P2;
				`IOPM_ADDR_SEL_P3: sel_p3_reg <= pwdata[7:0] & `IOPM_MASK_SEL_P3;
				default: sel_p0_reg <= sel_p0_reg;
			endcase
		end
	end

	// gpio direction and output data, byte lanes honoured
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			gpio_dir_reg <= `IOPM_RST_PINS;
			gpio_out_reg <= `IOPM_RST_PINS;
		end else if (wr_done) begin
			if (paddr == `IOPM_ADDR_GPIO_DIR) begin
				gpio_dir_reg <= (gpio_dir_reg & ~wmask[27:0]) | (pwdata[27:0] & wmask[27:0]);
			end
			if (paddr == `IOPM_ADDR_GPIO_OUT) begin
				gpio_out_reg <= (gpio_out_reg & ~wmask[27:0]) | (pwdata[27:0] & wmask[27:0]);
			end
		end
	end

	// per-pin cells; select layout comes from the header masks
	assign sel_all = {sel_p3_reg[3:0], sel_p2_reg, sel_p1_reg, sel_p0_reg};
	for (genvar i = 0; i < 28; i++) begin : g_pin
		iopm_pin_cell #(
			.HAS_SEL(PIN_HAS_SEL[i]),
			.INV_SEL(PIN_INV_SEL[i]),
			.SHARED_IN(PIN_SHARED_IN[i])
		) u_cell (
			.clk_sys(clk_sys),
			.sys_rst(sys_rst),
			.sel_bit(sel_all[i]),
			.gpio_dir(gpio_dir_reg[i]),
			.gpio_out(gpio_out_reg[i]),
			.periph_out(periph.out[i]),
			.periph_drive(periph.drive[i]),
			.periph_in(periph_in[i]),
			.pad_in(pad_in[i]),
			.pad_out(pad_out_w[i]),
			.pad_oe_n(pad_oe_n_w[i]),
			.gpio_in(gpio_in_w[i])
		);
	end
	assign pads = {pad_out_w, pad_oe_n_w};

	// key-entry reset sees the low port zero pins regardless of function
	assign key_reset_in = gpio_in_w[3:0];

	// arm edge detection only once the previous sample holds a pad level;
	// the cost is that a pin change in the first cycle after reset is missed
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			in_valid_reg <= 1'b0;
			evt_armed_reg <= 1'b0;
		end else begin
			in_valid_reg <= 1'b1;
			evt_armed_reg <= in_valid_reg;
		end
	end

	// any edge on port zero or one is an event; ports two, three never
	assign pin_event = evt_armed_reg ? (gpio_in_w[15:0] ^ gpio_prev_reg) : 16'h0000;
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			gpio_prev_reg <= `IOPM_RST_IRQ;
		end else begin
			gpio_prev_reg <= gpio_in_w[15:0];
		end
	end

	// sticky status, write one to clear; a new event beats the clear
	always_comb begin
		irq_status_next = irq_status_reg;
		if (wr_done && paddr == `IOPM_ADDR_IRQ_STATUS) begin
			irq_status_next = irq_status_reg & ~(pwdata[15:0] & wmask[15:0]);
		end
		irq_status_next = irq_status_next | pin_event;
	end

	// status, mask and the registered interrupt line
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			irq_status_reg <= `IOPM_RST_IRQ;
			irq_mask_reg <= `IOPM_RST_IRQ;
			irq <= 1'b0;
		end else begin
			irq_status_reg <= irq_status_next;
			if (wr_done && paddr == `IOPM_ADDR_IRQ_MASK) begin
				irq_mask_reg <= (irq_mask_reg & ~wmask[15:0]) | (pwdata[15:0] & wmask[15:0]);
			end
			irq <= |(irq_status_reg & irq_mask_reg);
		end
	end

	// reset, register contents and routing
	reset_sel_a: assert property (@(posedge clk_sys)
		sys_rst |=> {sel_p0_reg, sel_p1_reg, sel_p2_reg, sel_p3_reg} == 32'h00000000)
		else $error("select bits not cleared by reset");
	unimpl_zero_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		((sel_p0_reg & ~`IOPM_MASK_SEL_P0) == 8'h00) && ((sel_p1_reg & ~`IOPM_MASK_SEL_P1) == 8'h00)
		&& ((sel_p3_reg & ~`IOPM_MASK_SEL_P3) == 8'h00))
		else $error("unimplemented select bit set");
	sel_write_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		wr_done && pstrb[0] && paddr == `IOPM_ADDR_SEL_P1
		|=> sel_p1_reg == ($past(pwdata[7:0]) & `IOPM_MASK_SEL_P1))
		else $error("select write did not land");
	remote_route_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		sel_p0_reg[5] && periph.drive[5] |=> !pads.oe_n[5] && pads.out[5] == $past(periph.out[5]))
		else $error("remote control output not routed");
	debug_inv_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!sel_p3_reg[1] |=> pads.oe_n[25] == !$past(periph.drive[25]))
		else $error("debug pin not owned by debug logic");
	uart_route_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		sel_p2_reg[4] |=> pads.out[20] == $past(periph.out[20]))
		else $error("uart transmit not routed");
	event_sticky_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		pin_event != 16'h0000 |=> (irq_status_reg & $past(pin_event)) == $past(pin_event))
		else $error("pin edge lost in status");
	irq_level_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(irq_status_reg & irq_mask_reg) != 16'h0000 |=> irq)
		else $error("unmasked status did not raise interrupt");
	key_reset_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		##1 key_reset_in == $past(pad_in[3:0]))
		else $error("key reset input not following pad");
	apb_ready_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		psel && !penable |=> pready)
		else $error("apb answer late");

	// apb answer: refusal, write data and select readback
	unmapped_error_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		setup_ph && !addr_hit |=> pslverr && pready)
		else $error("unmapped access not refused");
	write_data_zero_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		setup_ph && pwrite |=> prdata == 32'h00000000)
		else $error("read data not zero on write");
	sel_read_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		setup_ph && !pwrite && paddr == `IOPM_ADDR_SEL_P1
		|=> prdata == {24'h000000, $past(sel_p1_reg)})
		else $error("select register read back wrong");

	// select writes land masked; without the low strobe nothing moves
	sel_p0_write_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		wr_done && pstrb[0] && paddr == `IOPM_ADDR_SEL_P0
		|=> sel_p0_reg == ($past(pwdata[7:0]) & `IOPM_MASK_SEL_P0))
		else $error("port zero select write did not land");
	sel_p2_write_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		wr_done && pstrb[0] && paddr == `IOPM_ADDR_SEL_P2
		|=> sel_p2_reg == ($past(pwdata[7:0]) & `IOPM_MASK_SEL_P2))
		else $error("port two select write did not land");
	sel_p3_write_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		wr_done && pstrb[0] && paddr == `IOPM_ADDR_SEL_P3
		|=> sel_p3_reg == ($past(pwdata[7:0]) & `IOPM_MASK_SEL_P3))
		else $error("port three select write did not land");
	strobe_ignore_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		wr_done && !pstrb[0] |=> $stable(sel_all))
		else $error("select bits changed without low byte strobe");

	// single pins of each kind
	spi_select_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		sel_p1_reg[7] |=> pads.out[15] == $past(periph.out[15]))
		else $error("spi select not routed");
	osc_out_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		sel_p3_reg[0] |=> pads.out[24] == $past(periph.out[24]))
		else $error("second clock output not routed");
	debug_release_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		sel_p3_reg[1] |=> pads.oe_n[25] == !$past(gpio_dir_reg[25]))
		else $error("debug pin not released to gpio");
	fixed_gpio_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		##1 pads.oe_n[0] == !$past(gpio_dir_reg[0]) && pads.out[0] == $past(gpio_out_reg[0]))
		else $error("pin without select bit left gpio");
	dir_ignored_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		sel_p2_reg[1] && !periph.drive[17] |=> pads.oe_n[17])
		else $error("gpio direction drove a routed pin");
	timer_feed_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!gpio_dir_reg[14] |=> periph_in[14] == $past(pad_in[14]))
		else $error("timer clock input not fed");

	// interrupt status and line
	irq_low_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(irq_status_reg & irq_mask_reg) == 16'h0000 |=> !irq)
		else $error("interrupt raised without unmasked status");
	status_clear_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		wr_done && paddr == `IOPM_ADDR_IRQ_STATUS
		|=> (irq_status_reg & $past(pwdata[15:0] & wmask[15:0] & ~pin_event)) == 16'h0000)
		else $error("status bit not cleared by write one");
	quiet_start_a: assert property (@(posedge clk_sys)
		sys_rst ##1 !sys_rst |=> ##1 irq_status_reg == 16'h0000)
		else $error("false pin edge after reset");

endmodule

// ---- testbench/iopm_far_side.sv ----
// far side model: package pins and the on-chip peripherals behind the mux
`timescale 1ns/1ps
module iopm_far_side (
	// design pad drive
	input wire iopm_pkg::iopm_pad_t pads,
	// scenario controls
	input wire logic [27:0] ext_level,
	input wire logic [27:0] per_out,
	input wire logic [27:0] per_drive,
	// towards the design
	output logic [27:0] pad_in,
	output iopm_pkg::iopm_periph_t periph
);
	// wire level: the design's value where it drives, else the board source
	always_comb begin
		for (int k = 0; k < 28; k++) begin
			pad_in[k] = pads.oe_n[k] ? ext_level[k] : pads.out[k];
		end
	end

	// peripherals hold value and drive request; no filter, so no prescaler start
	assign periph = {per_out, per_drive};
endmodule

// ---- testbench/io_port_pin_function_mux_tb.sv ----
// self-checking testbench of the pin function multiplexer
`timescale 1ns/1ps
`include "iopm_regs.svh"
module io_port_pin_function_mux_tb;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [19:0] paddr = 20'h00000;
	logic [31:0] pwdata = 32'h00000000;
	logic [3:0] pstrb = 4'hF;
	logic [31:0] prdata, q;
	logic pready, pslverr, irq, e;
	logic [3:0] key_reset_in;
	logic [27:0] pad_in, periph_in;
	logic [27:0] ext = 28'h0000000;
	logic [27:0] pout = 28'h0000000;
	logic [27:0] pdrv = 28'h0000000;
	iopm_pkg::iopm_pad_t pads;
	iopm_pkg::iopm_periph_t periph;
	int err_total = 0;
	int checked = 0;
	logic [7:0] m [4] = '{`IOPM_MASK_SEL_P0, `IOPM_MASK_SEL_P1, `IOPM_MASK_SEL_P2, `IOPM_MASK_SEL_P3};
	localparam logic [27:0] R = `IOPM_PIN_HAS_SEL & ~`IOPM_PIN_INV_SEL;
	localparam logic [27:0] D = 28'h5555555;
	localparam logic [27:0] P = 28'hA5C3E96;
	localparam logic [27:0] G = 28'h9E3C5A1;

	// 100 MHz system clock
	always #5 clk_sys = ~clk_sys;

	iopm_pin_mux iopm_pin_mux_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .pad_in(pad_in), .pads(pads),
		.periph(periph), .periph_in(periph_in), .key_reset_in(key_reset_in), .irq(irq));

	iopm_far_side iopm_far_side_i (.pads(pads), .ext_level(ext), .per_out(pout),
		.per_drive(pdrv), .pad_in(pad_in), .periph(periph));

	// one apb transfer; only the watchdog ends a wait for pready
	task automatic apb(input logic w, input logic [19:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		checked++;
		if (g !== x) begin
			$display("FAIL %s expected %h seen %h", nm, x, g);
			err_total++;
		end
	endtask

	task automatic summarize;
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// watchdog: the tests need little more than a hundred cycles
	initial begin
		repeat (20000) @(posedge clk_sys);
		err_total++;
		summarize();
	end

	// main sequence
	initial begin
		repeat (16) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		chk("oe_n", 32'h0FFFFFFF, {4'h0, pads.oe_n});
		// peripheral clock runs throughout, so register access is always allowed
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, `IOPM_ADDR_SEL_P0 + 20'(4 * i), 32'h0);
			chk("sel reset", 32'h0, q);
		end
		// input interrupts on any pin edge, here a rising one, only low sixteen pins
		apb(1'b1, `IOPM_ADDR_IRQ_MASK, 32'h0000FFFF);
		ext <= 28'hFFFFFFF;
		repeat (4) @(posedge clk_sys);
		chk("irq", 32'h1, {31'h0, irq});
		chk("periph_in", {4'h0, `IOPM_PIN_SHARED_IN | `IOPM_PIN_INV_SEL}, {4'h0, periph_in});
		chk("key_reset_in", 32'hF, {28'h0, key_reset_in});
		apb(1'b0, `IOPM_ADDR_GPIO_IN, 32'h0);
		chk("gpio in", 32'h0FFFFFFF, q);
		apb(1'b0, `IOPM_ADDR_IRQ_STATUS, 32'h0);
		chk("status", 32'h0000FFFF, q);
		apb(1'b1, `IOPM_ADDR_IRQ_MASK, 32'h0);
		repeat (2) @(posedge clk_sys);
		chk("irq masked", 32'h0, {31'h0, irq});
		apb(1'b1, `IOPM_ADDR_IRQ_STATUS, 32'h0000FFFF);
		apb(1'b0, `IOPM_ADDR_IRQ_STATUS, 32'h0);
		chk("status cleared", 32'h0, q);
		// unmapped word is refused
		apb(1'b0, 20'h14AA4, 32'h0);
		chk("pslverr", 32'h1, {31'h0, e});
		chk("unmapped data", 32'h0, q);
		// a write without the low byte strobe leaves the select bits alone
		pstrb <= 4'hE;
		apb(1'b1, `IOPM_ADDR_SEL_P2, 32'h000000FF);
		pstrb <= 4'hF;
		apb(1'b0, `IOPM_ADDR_SEL_P2, 32'h0);
		chk("strobe ignored", 32'h0, q);
		// unimplemented select bits read zero
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, `IOPM_ADDR_SEL_P0 + 20'(4 * i), 32'hFFFFFFFF);
			apb(1'b0, `IOPM_ADDR_SEL_P0 + 20'(4 * i), 32'h0);
			chk("sel readback", {24'h0, m[i]}, q);
		end
		// routed pins follow the peripheral, gpio direction ignored there
		apb(1'b1, `IOPM_ADDR_GPIO_DIR, 32'h0FFFFFFF);
		apb(1'b1, `IOPM_ADDR_GPIO_OUT, 32'h0);
		pdrv <= D;
		pout <= P;
		repeat (3) @(posedge clk_sys);
		chk("routed oe_n", {4'h0, ~D & R}, {4'h0, pads.oe_n});
		chk("routed out", {4'h0, P & D & R}, {4'h0, pads.out & ~pads.oe_n});
		// selects back to zero: gpio again, debug owns the inverted pins
		for (int i = 0; i < 4; i++) apb(1'b1, `IOPM_ADDR_SEL_P0 + 20'(4 * i), 32'h0);
		apb(1'b1, `IOPM_ADDR_GPIO_OUT, {4'h0, G});
		repeat (3) @(posedge clk_sys);
		chk("gpio oe_n", {4'h0, ~D & `IOPM_PIN_INV_SEL}, {4'h0, pads.oe_n});
		chk("gpio out", {7'h0, G[24:0]}, {7'h0, pads.out[24:0]});
		summarize();
	end
endmodule
